// ==== hdl/oscsd_cfg.svh ====
/*
 * Constants of the oscillator select and divide block: register offsets,
 * field positions, reset values, codes and timing figures.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef OSCSD_CFG_SVH
`define OSCSD_CFG_SVH

// Clock and timing
`define OSCSD_CLK_PERIOD_NS 5
`define OSCSD_PLL_STARTUP_NS 20000
`define OSCSD_PLL_STARTUP_CYC ((`OSCSD_PLL_STARTUP_NS + `OSCSD_CLK_PERIOD_NS - 1) / `OSCSD_CLK_PERIOD_NS)
`define OSCSD_LOCK_CNT_W 13
`define OSCSD_DIV_CNT_W 16

// Register byte offsets
`define OSCSD_ADDR_OSC_CTRL 5'h00
`define OSCSD_ADDR_CLK_DIV 5'h04
`define OSCSD_ADDR_UNLOCK 5'h08
`define OSCSD_ADDR_REF_CTRL 5'h0C
`define OSCSD_ADDR_AUX_STAT 5'h10

// Oscillator control fields
`define OSCSD_F_CUR 14:12
`define OSCSD_F_NXT 10:8
`define OSCSD_B_LOCK 7
`define OSCSD_B_PLL_LOCK 5
`define OSCSD_B_FAIL 3
`define OSCSD_B_SWREQ 0

// Clock divisor fields and reset value
`define OSCSD_B_ROI 15
`define OSCSD_F_DOZE 14:12
`define OSCSD_B_DOZE_ENABLE 11
`define OSCSD_F_RCPOST 10:8
`define OSCSD_F_PPOST 7:6
`define OSCSD_F_PPRE 4:0
`define OSCSD_CLK_DIV_RST 16'h3040

// Reference control fields
`define OSCSD_B_REF_EN 15
`define OSCSD_B_REF_SEL 12
`define OSCSD_F_REF_DIV 11:8

// Aux status fields
`define OSCSD_B_AUX_FINE 15
`define OSCSD_F_AUX_MULT 4:0
`define OSCSD_AUX_MULT 5'h10

// Source codes and RC postscaler limits
`define OSCSD_SRC_FRC 3'h0
`define OSCSD_SRC_FRC_PLL 3'h1
`define OSCSD_SRC_PRI_PLL 3'h3
`define OSCSD_RC_CODE_MAX 3'h7
`define OSCSD_RC_SHIFT_MAX 4'h8

// PLL divider codes
`define OSCSD_PPOST_RSVD 2'h2
`define OSCSD_PPRE_OFFSET 6'h02

// Monitor configuration: switching on, monitor off; switching-off bit
`define OSCSD_MON_SW_ONLY 2'h1
`define OSCSD_MON_SW_OFF_BIT 1

// Unlock keys
`define OSCSD_KEY_FIRST 16'h5A3C
`define OSCSD_KEY_SECOND 16'hC3A5

`endif

// ==== hdl/oscsd_pkg.sv ====
/*
 * Types of the oscillator select and divide block: the state records of
 * each module and the switch sequencer states.
 * Assumes oscsd_cfg.svh is on the include path.
 */
`include "oscsd_cfg.svh"

package oscsd_pkg;

  // Switch sequencer
  typedef enum logic [1:0] {
    OSCSD_SW_INIT = 2'b00,
    OSCSD_SW_IDLE = 2'b01,
    OSCSD_SW_WAIT = 2'b10
  } oscsd_sw_t;

  // Unlock progress
  typedef enum logic [1:0] {
    OSCSD_UL_NONE = 2'b00,
    OSCSD_UL_HALF = 2'b01,
    OSCSD_UL_OPEN = 2'b10
  } oscsd_ul_t;

  // Power-of-two divider state
  typedef struct packed {
    logic [`OSCSD_DIV_CNT_W-1:0] cnt;
    logic tick;
  } oscsd_div_t;

  // Start-up timer state
  typedef struct packed {
    logic [`OSCSD_LOCK_CNT_W-1:0] cnt;
    logic done;
  } oscsd_tmr_t;

  // Top state
  typedef struct packed {
    logic wait_r;
    logic [31:0] rdata;
    oscsd_ul_t ul;
    oscsd_sw_t st;
    logic [2:0] cur;
    logic [2:0] nxt;
    logic sw_req;
    logic clk_lock;
    logic cf;
    logic pll_lock;
    logic [15:0] div;
    logic ref_en;
    logic ref_sel;
    logic [3:0] ref_div;
    logic ref_clk;
    logic instr_tick;
    logic periph_tick;
    logic fine_res;
    logic [4:0] aux_mult;
    logic [5:0] pre_div;
    logic [3:0] post_div;
  } oscsd_top_t;

endpackage : oscsd_pkg

// ==== hdl/oscsd_pow2_div.sv ====
/*
 * Power-of-two divider of a tick stream: one output pulse per 2**shift
 * input ticks. Assumes ticks are one-cycle enables in the clk_in domain.
 */
`include "oscsd_cfg.svh"

module oscsd_pow2_div #(
  parameter int SHIFT_MAX = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Tick in, ratio, tick out
  input wire logic tick_in,
  input wire logic [3:0] shift_in,
  output logic tick_out
);
  import oscsd_pkg::*;

  // Counter must hold the widest ratio
  generate
    if (SHIFT_MAX >= `OSCSD_DIV_CNT_W) begin : g_bad
      $error("oscsd_pow2_div: SHIFT_MAX too large");
    end
  endgenerate

  oscsd_div_t s_q, s_d;
  logic [`OSCSD_DIV_CNT_W-1:0] mask;

  // Next state: pulse when the low shift bits are all ones
  always_comb begin
    mask = (`OSCSD_DIV_CNT_W'(1) << shift_in) - `OSCSD_DIV_CNT_W'(1);
    s_d = s_q;
    s_d.tick = tick_in && ((s_q.cnt & mask) == mask);
    if (tick_in) begin
      s_d.cnt = s_q.cnt + `OSCSD_DIV_CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.tick;

endmodule : oscsd_pow2_div

// ==== hdl/oscsd_lock_timer.sv ====
/*
 * PLL start-up timer: counts while enabled, reports done when the count
 * is reached, restarts whenever the enable drops.
 */
`include "oscsd_cfg.svh"

module oscsd_lock_timer #(
  parameter int CYCLES = `OSCSD_PLL_STARTUP_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Control and status
  input wire logic enable_in,
  output logic done_out
);
  import oscsd_pkg::*;

  // Count must fit the counter and be at least one
  generate
    if (CYCLES < 1 || CYCLES >= (1 << `OSCSD_LOCK_CNT_W)) begin : g_bad
      $error("oscsd_lock_timer: CYCLES out of range");
    end
  endgenerate

  localparam logic [`OSCSD_LOCK_CNT_W-1:0] LAST = `OSCSD_LOCK_CNT_W'(CYCLES - 1);

  oscsd_tmr_t s_q, s_d;

  // Next state
  always_comb begin
    s_d = s_q;
    if (!enable_in) begin
      s_d = '0;
    end else if (s_q.cnt == LAST) begin
      s_d.done = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + `OSCSD_LOCK_CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_out = s_q.done;

endmodule : oscsd_lock_timer

// ==== hdl/oscsd_top.sv ====
/*
 * Oscillator select and divide block: source switch sequencer, PLL lock
 * status, clock-fail flag, doze ratio, fast RC postscaler, PLL divider
 * decode, aux PLL status and reference clock output, behind an Avalon-MM
 * slave with waitrequest. Assumes oscillators appear as synchronous
 * ready levels and tick enables in the clk_in domain, and that
 * straps are stable at reset release.
 */
`include "oscsd_cfg.svh"

// Summary of operation
// - Aux PLL multiplies by fixed sixteen.
// - Fine PWM resolution only via aux PLL.
// - Reference output divides system or crystal clock.
// - Read-only field reports active oscillator code.
// - Writable next source, reset from straps.
// - Request bit starts switch, cleared on completion.
// - Lock bit blocks switching in monitor-off mode.
// - Lock status: locked or timer done, else zero.
// - Fail flag sticky until software clears it.
// - Oscillator control writes need prior unlock sequence.
// - Interrupt clears doze enable when recover set.
// - Doze field divides processor clock 1 to 128.
// - Doze off forces one-to-one clock ratio.
// - RC postscaler divides 1 to 64, then 256.
// - PLL output divider 2, 4, 8; code reserved.
// - PLL input divider is code plus two.
// - Instruction clock is half the oscillator.
module oscsd_top #(
  parameter int LOCK_CYCLES = `OSCSD_PLL_STARTUP_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Configuration straps
  input wire logic [2:0] cfg_initial_source_in,
  input wire logic [1:0] switch_monitor_config_in,
  // Oscillator and PLL status
  input wire logic [7:0] source_ready_in,
  input wire logic pll_phase_lock_in,
  input wire logic failsafe_monitor_fail_in,
  input wire logic fast_rc_tick_in,
  input wire logic crystal_tick_in,
  input wire logic aux_from_aux_pll_in,
  // Interrupt activity
  input wire logic irq_in,
  // Clock status and enables
  output logic [2:0] current_source_sel_out,
  output logic pll_locked_out,
  output logic instr_tick_out,
  output logic periph_tick_out,
  output logic cpu_tick_out,
  output logic rc_div_tick_out,
  output logic ref_clk_out,
  output logic [5:0] pll_input_divisor_out,
  output logic [3:0] pll_output_divisor_out,
  output logic [4:0] aux_pll_mult_out,
  output logic pwm_fine_res_out
);
  import oscsd_pkg::*;

  oscsd_top_t s_q, s_d;
  logic timer_done; // Start-up timer expired
  logic pll_en; // PLL in use or being switched to
  logic cpu_tick; // Doze divider output
  logic rc_tick; // RC postscaler output
  logic ref_tick; // Reference divider output
  logic [3:0] doze_shift; // Effective processor ratio
  logic [3:0] rc_shift; // Effective RC ratio
  logic ref_src_tick; // Reference source enable
  logic wr_go; // Write completes this edge
  logic [15:0] wd; // Merged write value
  logic osc_open; // Unlock sequence satisfied
  logic sw_allowed; // Switching permitted now

  // True for the two PLL source codes
  function automatic logic is_pll(input logic [2:0] code);
    return (code == `OSCSD_SRC_FRC_PLL) || (code == `OSCSD_SRC_PRI_PLL);
  endfunction : is_pll

  // Byte-lane merge of the low halfword
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] be);
    return {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : merge16

  // Output divider code to ratio; reserved never stored
  function automatic logic [3:0] post_ratio(input logic [1:0] code);
    case (code)
      2'h0: return 4'h2;
      2'h1: return 4'h4;
      default: return 4'h8;
    endcase
  endfunction : post_ratio

  function automatic logic [31:0] read_reg(input oscsd_top_t s, input logic [4:0] a);
    logic [15:0] v;
    v = '0;
    case (a)
      `OSCSD_ADDR_OSC_CTRL: begin
        v[`OSCSD_F_CUR] = s.cur;
        v[`OSCSD_F_NXT] = s.nxt;
        v[`OSCSD_B_LOCK] = s.clk_lock;
        v[`OSCSD_B_PLL_LOCK] = s.pll_lock;
        v[`OSCSD_B_FAIL] = s.cf;
        v[`OSCSD_B_SWREQ] = s.sw_req;
      end
      `OSCSD_ADDR_CLK_DIV: v = s.div;
      `OSCSD_ADDR_REF_CTRL: begin
        v[`OSCSD_B_REF_EN] = s.ref_en;
        v[`OSCSD_B_REF_SEL] = s.ref_sel;
        v[`OSCSD_F_REF_DIV] = s.ref_div;
      end
      `OSCSD_ADDR_AUX_STAT: begin
        v[`OSCSD_B_AUX_FINE] = s.fine_res;
        v[`OSCSD_F_AUX_MULT] = s.aux_mult;
      end
      default: v = '0;
    endcase
    return {16'h0000, v};
  endfunction : read_reg

  // Divider ratios for the submodules
  always_comb begin
    doze_shift = s_q.div[`OSCSD_B_DOZE_ENABLE] ? {1'b0, s_q.div[`OSCSD_F_DOZE]} : 4'h0;
    rc_shift = (s_q.div[`OSCSD_F_RCPOST] == `OSCSD_RC_CODE_MAX) ? `OSCSD_RC_SHIFT_MAX
                                                                  : {1'b0, s_q.div[`OSCSD_F_RCPOST]};
    ref_src_tick = s_q.ref_sel ? crystal_tick_in : 1'b1;
    pll_en = is_pll(s_q.cur) || ((s_q.st == OSCSD_SW_WAIT) && is_pll(s_q.nxt));
  end

  oscsd_pow2_div #(
    .SHIFT_MAX(7)
  ) u_doze_div (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .tick_in(s_q.instr_tick),
    .shift_in(doze_shift),
    .tick_out(cpu_tick)
  );

  // Fast RC postscaler
  oscsd_pow2_div #(
    .SHIFT_MAX(8)
  ) u_rc_div (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .tick_in(fast_rc_tick_in),
    .shift_in(rc_shift),
    .tick_out(rc_tick)
  );

  // Reference output prescale
  oscsd_pow2_div #(
    .SHIFT_MAX(15)
  ) u_ref_div (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .tick_in(ref_src_tick && s_q.ref_en),
    .shift_in(s_q.ref_div),
    .tick_out(ref_tick)
  );

  // PLL start-up timer, restarts whenever the PLL is idle
  oscsd_lock_timer #(
    .CYCLES(LOCK_CYCLES)
  ) u_lock_tmr (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .enable_in(pll_en),
    .done_out(timer_done)
  );

  // Next-state logic: bus, registers, sequencer
  always_comb begin
    s_d = s_q;
    wr_go = avs_write_in && !s_q.wait_r;
    wd = merge16(16'h0000, avs_writedata_in, avs_byteenable_in);
    osc_open = (s_q.ul == OSCSD_UL_OPEN);
    // lock honoured only in switch-only mode
    sw_allowed = !switch_monitor_config_in[`OSCSD_MON_SW_OFF_BIT]
                 && !(s_q.clk_lock && (switch_monitor_config_in == `OSCSD_MON_SW_ONLY));

    // Free-running enables; halving the oscillator rate
    // instruction tick every other clock
    s_d.instr_tick = !s_q.instr_tick;
    s_d.periph_tick = s_q.instr_tick;
    s_d.ref_clk = s_q.ref_en ? (s_q.ref_clk ^ ref_tick) : 1'b0;
    s_d.aux_mult = `OSCSD_AUX_MULT;
    // fine resolution only from aux PLL
    s_d.fine_res = aux_from_aux_pll_in;
    // input divisor is code plus two
    s_d.pre_div = {1'b0, s_q.div[`OSCSD_F_PPRE]} + `OSCSD_PPRE_OFFSET;
    s_d.post_div = post_ratio(s_q.div[`OSCSD_F_PPOST]);
    // locked or timer expired, only while enabled
    s_d.pll_lock = pll_en && (pll_phase_lock_in || timer_done);

    // Bus handshake: one wait cycle, then answer
    if ((avs_read_in || avs_write_in) && s_q.wait_r) begin
      s_d.wait_r = 1'b0;
      s_d.rdata = avs_read_in ? read_reg(s_q, avs_address_in) : 32'h0000_0000;
    end else if (!s_q.wait_r) begin
      s_d.wait_r = 1'b1;
    end

    // Register writes
    if (wr_go) begin
      // Any write, a key included, consumes the unlock
      s_d.ul = OSCSD_UL_NONE;
      case (avs_address_in)
        `OSCSD_ADDR_UNLOCK: begin
          if (wd == `OSCSD_KEY_FIRST) begin
            s_d.ul = OSCSD_UL_HALF;
          end else if (s_q.ul == OSCSD_UL_HALF && wd == `OSCSD_KEY_SECOND) begin
            s_d.ul = OSCSD_UL_OPEN;
          end
        end
        `OSCSD_ADDR_OSC_CTRL: begin
          if (osc_open) begin
            wd = merge16({1'b0, s_q.cur, 1'b0, s_q.nxt, s_q.clk_lock, 6'h00, s_q.sw_req},
                         avs_writedata_in, avs_byteenable_in);
            s_d.nxt = wd[`OSCSD_F_NXT];
            s_d.clk_lock = wd[`OSCSD_B_LOCK];
            // Writing zero clears the fail flag
            if (avs_byteenable_in[0] && !wd[`OSCSD_B_FAIL]) begin
              s_d.cf = 1'b0;
            end
            if (wd[`OSCSD_B_SWREQ] && sw_allowed) begin
              s_d.sw_req = 1'b1;
            end
          end
        end
        `OSCSD_ADDR_CLK_DIV: begin
          wd = merge16(s_q.div, avs_writedata_in, avs_byteenable_in);
          wd[5] = 1'b0;
          if (wd[`OSCSD_F_PPOST] == `OSCSD_PPOST_RSVD) begin
            wd[`OSCSD_F_PPOST] = s_q.div[`OSCSD_F_PPOST];
          end
          s_d.div = wd;
        end
        `OSCSD_ADDR_REF_CTRL: begin
          wd = merge16({s_q.ref_en, 2'b00, s_q.ref_sel, s_q.ref_div, 8'h00},
                       avs_writedata_in, avs_byteenable_in);
          s_d.ref_en = wd[`OSCSD_B_REF_EN];
          s_d.ref_sel = wd[`OSCSD_B_REF_SEL];
          s_d.ref_div = wd[`OSCSD_F_REF_DIV];
        end
        default: begin
          // Unmapped or read-only: ignored
        end
      endcase
    end

    // failure sets, wins over a clear
    if (failsafe_monitor_fail_in && (switch_monitor_config_in == 2'h0)) begin
      s_d.cf = 1'b1;
    end

    // interrupt drops doze when recover set
    if (irq_in && s_q.div[`OSCSD_B_ROI]) begin
      s_d.div[`OSCSD_B_DOZE_ENABLE] = 1'b0;
    end

    // Switch sequencer
    case (s_q.st)
      OSCSD_SW_INIT: begin
        s_d.cur = cfg_initial_source_in;
        s_d.nxt = cfg_initial_source_in;
        s_d.st = OSCSD_SW_IDLE;
      end
      OSCSD_SW_IDLE: begin
        if (s_q.sw_req) begin
          s_d.st = OSCSD_SW_WAIT;
        end
      end
      OSCSD_SW_WAIT: begin
        // commit source only when target ready
        if (source_ready_in[s_q.nxt] && (!is_pll(s_q.nxt) || s_q.pll_lock)) begin
          s_d.cur = s_q.nxt;
          s_d.sw_req = 1'b0;
          s_d.st = OSCSD_SW_IDLE;
        end
      end
      default: s_d.st = OSCSD_SW_IDLE;
    endcase
  end

  // State register; straps are never loaded under reset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
      s_q.wait_r <= 1'b1;
      s_q.st <= OSCSD_SW_INIT;
      s_q.div <= `OSCSD_CLK_DIV_RST;
      s_q.aux_mult <= `OSCSD_AUX_MULT;
      s_q.pre_div <= `OSCSD_PPRE_OFFSET;
      s_q.post_div <= 4'h4;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign avs_readdata_out = s_q.rdata;
  assign avs_waitrequest_out = s_q.wait_r;
  assign current_source_sel_out = s_q.cur;
  assign pll_locked_out = s_q.pll_lock;
  assign instr_tick_out = s_q.instr_tick;
  assign periph_tick_out = s_q.periph_tick;
  assign cpu_tick_out = cpu_tick;
  assign rc_div_tick_out = rc_tick;
  assign ref_clk_out = s_q.ref_clk;
  assign pll_input_divisor_out = s_q.pre_div;
  assign pll_output_divisor_out = s_q.post_div;
  assign aux_pll_mult_out = s_q.aux_mult;
  assign pwm_fine_res_out = s_q.fine_res;

endmodule : oscsd_top

// ==== tb/oscsd_top_assertions.sv ====
/*
 * Port checker of the oscillator select and divide block.
 * Assumes one clock domain; bound by the bind at the foot.
 */
module oscsd_top_chk (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Register bus
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // Status in and out
  input wire logic [7:0] source_ready_in,
  input wire logic aux_from_aux_pll_in,
  input wire logic [2:0] current_source_sel_out,
  input wire logic pll_locked_out,
  input wire logic instr_tick_out,
  input wire logic periph_tick_out,
  input wire logic [5:0] pll_input_divisor_out,
  input wire logic [3:0] pll_output_divisor_out,
  input wire logic [4:0] aux_pll_mult_out,
  input wire logic pwm_fine_res_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Read completing this cycle
  logic rd_done;
  // Ready levels one edge back
  logic [7:0] rdy_q;
  assign rd_done = avs_read_in && !avs_waitrequest_out;
  // Delay of ready levels
  always_ff @(posedge clk_in) begin
    rdy_q <= source_ready_in;
  end
  a_aux_mult_fixed: assert property (aux_pll_mult_out == 5'h10)
    else $error("aux multiplier not sixteen");
  a_aux_stat_read: assert property (rd_done && avs_address_in == 5'h10 |-> avs_readdata_out[4:0] == 5'h10)
    else $error("aux status multiplier wrong");
  a_fine_res_src: assert property ($past(resetn_in) |-> pwm_fine_res_out == $past(aux_from_aux_pll_in))
    else $error("fine resolution flag wrong");
  a_instr_half_rate: assert property (instr_tick_out |=> !instr_tick_out && periph_tick_out)
    else $error("instruction tick not half rate");
  a_in_div_range: assert property (pll_input_divisor_out inside {[6'h02:6'h21]})
    else $error("input divisor out of range");
  a_out_div_legal: assert property (pll_output_divisor_out inside {4'h2, 4'h4, 4'h8})
    else $error("output divisor illegal");
  a_div_rsvd_read: assert property (rd_done && avs_address_in == 5'h04 |->
    avs_readdata_out[7:6] != 2'b10 && !avs_readdata_out[5])
    else $error("divisor register shows reserved value");
  a_osc_rsvd_read: assert property (rd_done && avs_address_in == 5'h00 |-> {avs_readdata_out[15],
    avs_readdata_out[11], avs_readdata_out[6], avs_readdata_out[4], avs_readdata_out[2:1]} == 6'h00)
    else $error("control register unused bits set");
  a_cur_needs_ready: assert property ($past(resetn_in) && $changed(current_source_sel_out) |->
    rdy_q[current_source_sel_out] && (!(current_source_sel_out inside {3'h1, 3'h3}) || $past(pll_locked_out)))
    else $error("source changed before ready");
  // Main scenarios reached
  c_div_read: cover property (rd_done && avs_address_in == 5'h04);
  c_switch: cover property ($changed(current_source_sel_out));
  c_locked: cover property (pll_locked_out);
endmodule : oscsd_top_chk

bind oscsd_top oscsd_top_chk chk_u (.clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .source_ready_in(source_ready_in), .aux_from_aux_pll_in(aux_from_aux_pll_in),
  .current_source_sel_out(current_source_sel_out), .pll_locked_out(pll_locked_out),
  .instr_tick_out(instr_tick_out), .periph_tick_out(periph_tick_out),
  .pll_input_divisor_out(pll_input_divisor_out), .pll_output_divisor_out(pll_output_divisor_out),
  .aux_pll_mult_out(aux_pll_mult_out), .pwm_fine_res_out(pwm_fine_res_out));

// ==== tb/oscsd_tb_top.sv ====
/*
 * Self-checking bench of the oscillator select and divide block.
 * Assumes the package is compiled first.
 */
module oscsd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import oscsd_pkg::*;
  // Design inputs
  logic clk_in, resetn_in, avs_read_in, avs_write_in, pll_phase_lock_in, failsafe_monitor_fail_in;
  logic fast_rc_tick_in = 1'b0, crystal_tick_in = 1'b0, aux_from_aux_pll_in, irq_in;
  logic [4:0] avs_address_in;
  logic [31:0] avs_writedata_in;
  logic [3:0] avs_byteenable_in;
  logic [2:0] cfg_initial_source_in;
  logic [1:0] switch_monitor_config_in;
  logic [7:0] source_ready_in;
  // Design outputs
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out, pll_locked_out, instr_tick_out, periph_tick_out, cpu_tick_out;
  logic rc_div_tick_out, ref_clk_out, pwm_fine_res_out;
  logic [2:0] current_source_sel_out;
  logic [5:0] pll_input_divisor_out;
  logic [3:0] pll_output_divisor_out;
  logic [4:0] aux_pll_mult_out;
  // Tallies and tick counters
  int bad_count = 0, n_tests = 0, n_cpu, n_rc, n_ref, k;
  logic cnt_en, ref_prev = 1'b0;
  // Divisor writes, readback and decoded divisors
  logic [15:0] dw[4] = '{16'h001F, 16'h00C0, 16'h0080, 16'h0040};
  logic [15:0] de[4] = '{16'h001F, 16'h00C0, 16'h00C0, 16'h0040};
  logic [5:0] pin[4] = '{6'h21, 6'h02, 6'h02, 6'h02};
  logic [3:0] pout[4] = '{4'h2, 4'h8, 4'h8, 4'h4};

  oscsd_top #(.LOCK_CYCLES(8)) dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .cfg_initial_source_in(cfg_initial_source_in),
    .switch_monitor_config_in(switch_monitor_config_in), .source_ready_in(source_ready_in),
    .pll_phase_lock_in(pll_phase_lock_in), .failsafe_monitor_fail_in(failsafe_monitor_fail_in),
    .fast_rc_tick_in(fast_rc_tick_in), .crystal_tick_in(crystal_tick_in),
    .aux_from_aux_pll_in(aux_from_aux_pll_in), .irq_in(irq_in), .current_source_sel_out(current_source_sel_out),
    .pll_locked_out(pll_locked_out), .instr_tick_out(instr_tick_out), .periph_tick_out(periph_tick_out),
    .cpu_tick_out(cpu_tick_out), .rc_div_tick_out(rc_div_tick_out), .ref_clk_out(ref_clk_out),
    .pll_input_divisor_out(pll_input_divisor_out), .pll_output_divisor_out(pll_output_divisor_out),
    .aux_pll_mult_out(aux_pll_mult_out), .pwm_fine_res_out(pwm_fine_res_out));

  // 200 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Oscillator ticks every other cycle; tick counters cleared while idle
  always @(posedge clk_in) begin
    fast_rc_tick_in <= ~fast_rc_tick_in;
    crystal_tick_in <= ~crystal_tick_in;
    ref_prev <= ref_clk_out;
    n_cpu <= cnt_en ? n_cpu + int'(cpu_tick_out) : 0;
    n_rc <= cnt_en ? n_rc + int'(rc_div_tick_out) : 0;
    n_ref <= cnt_en ? n_ref + int'(ref_clk_out != ref_prev) : 0;
  end

  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Within one of the ideal; windows start at any phase
  function automatic logic [15:0] near(input int n, input int e);
    return (n >= e - 1 && n <= e + 1) ? 16'h0001 : 16'h0000;
  endfunction : near

  // One Avalon access, held until waitrequest is low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
    int i;
    i = 0;
    avs_address_in <= a;
    avs_writedata_in <= {16'h0000, d};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge clk_in);
      i++;
    end while (avs_waitrequest_out !== 1'b0 && i < 50);
    q = avs_readdata_out[15:0];
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
    if (i >= 50) begin
      chk(16'h0001, 16'h0000);
      complete_run();
    end
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(q, e);
  endtask : rd

  // Unlock keys, then the control write
  task automatic osc_wr(input logic [15:0] d);
    wr(5'h08, 16'h5A3C);
    wr(5'h08, 16'hC3A5);
    wr(5'h00, d);
  endtask : osc_wr

  // Bounded wait for a source code, then compare
  task automatic wait_cur(input logic [2:0] e);
    int i;
    i = 0;
    while (current_source_sel_out !== e && i < 200) begin
      @(posedge clk_in);
      i++;
    end
    chk({13'h0000, current_source_sel_out}, {13'h0000, e});
  endtask : wait_cur

  task automatic pulse(input logic f);
    {failsafe_monitor_fail_in, irq_in} <= {f, !f};
    @(posedge clk_in);
    {failsafe_monitor_fail_in, irq_in} <= 2'b00;
    @(posedge clk_in);
  endtask : pulse

  task automatic do_reset(input logic [1:0] cfg);
    resetn_in <= 1'b0;
    switch_monitor_config_in <= cfg;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask : do_reset

  // Main sequence
  initial begin
    {resetn_in, avs_read_in, avs_write_in, pll_phase_lock_in, failsafe_monitor_fail_in} = 5'h00;
    {irq_in, cnt_en} = 2'h0;
    {avs_address_in, avs_writedata_in, avs_byteenable_in} = {5'h00, 32'h0000_0000, 4'hF};
    {cfg_initial_source_in, switch_monitor_config_in, source_ready_in} = {3'h2, 2'h0, 8'h04};
    aux_from_aux_pll_in = 1'b1;
    do_reset(2'b00);
    rd(5'h04, 16'h3040);
    rd(5'h00, 16'h2200);
    rd(5'h10, 16'h8010);
    rd(5'h14, 16'h0000);
    chk({10'h000, pll_input_divisor_out}, 16'h0002);
    $display("Test reset values done");
    wr(5'h00, 16'h0001);
    rd(5'h00, 16'h2200);
    pulse(1'b1);
    rd(5'h00, 16'h2208);
    rd(5'h00, 16'h2208);
    osc_wr(16'h0200);
    rd(5'h00, 16'h2200);
    $display("Test unlock and fail flag done");
    osc_wr(16'h0001);
    rd(5'h00, 16'h2001);
    chk({13'h0000, current_source_sel_out}, 16'h0002);
    source_ready_in <= 8'hFF;
    wait_cur(3'h0);
    rd(5'h00, 16'h0000);
    osc_wr(16'h0301);
    wait_cur(3'h3);
    rd(5'h00, 16'h3320);
    // Back to plain fast RC from primary PLL
    osc_wr(16'h0001);
    wait_cur(3'h0);
    rd(5'h00, 16'h0000);
    $display("Test source switching done");
    do_reset(2'b01);
    osc_wr(16'h0080);
    osc_wr(16'h0081);
    rd(5'h00, 16'h2080);
    repeat (20) @(posedge clk_in);
    chk({13'h0000, current_source_sel_out}, 16'h0002);
    osc_wr(16'h0000);
    osc_wr(16'h0001);
    wait_cur(3'h0);
    $display("Test switch lock done");
    for (k = 0; k < 4; k++) begin
      wr(5'h04, dw[k]);
      rd(5'h04, de[k]);
      chk({10'h000, pll_input_divisor_out}, {10'h000, pin[k]});
      chk({12'h000, pll_output_divisor_out}, {12'h000, pout[k]});
    end
    wr(5'h04, 16'h8840);
    pulse(1'b0);
    rd(5'h04, 16'h8040);
    wr(5'h04, 16'h0840);
    pulse(1'b0);
    rd(5'h04, 16'h0840);
    $display("Test divisor fields done");
    // Ratios: rows 8 and 9 run with doze off, row 9 from crystal ticks
    for (k = 0; k < 10; k++) begin
      wr(5'h04, k < 8 ? {1'b0, k[2:0], 1'b1, k[2:0], 8'h40} : 16'h7040);
      wr(5'h0C, {1'b1, 2'b00, k == 9, k == 9 ? 4'h0 : k[3:0], 8'h00});
      repeat (8) @(posedge clk_in);
      cnt_en <= 1'b1;
      repeat (2048) @(posedge clk_in);
      cnt_en <= 1'b0;
      @(posedge clk_in);
      chk(near(n_cpu, k < 8 ? 1024 >> k : 1024), 16'h0001);
      chk(near(n_rc, 1024 >> (k == 7 ? 8 : (k < 8 ? k : 0))), 16'h0001);
      chk(near(n_ref, k == 9 ? 1024 : 2048 >> k), 16'h0001);
    end
    wr(5'h0C, 16'h0000);
    repeat (4) @(posedge clk_in);
    chk({15'h0000, ref_clk_out}, 16'h0000);
    $display("Test clock ratios done");
    complete_run();
  end
endmodule : oscsd_tb_top
